// ==== hdl/dcm_top.sv ====
// Channel organization: mode choice, address mapping, common timing.
// Assumes presence-detect data and channel setup held stable while running.
`timescale 1ns/100ps
module dcm_top #(
	parameter int ADDR_W = dcm_pkg::ADDR_W,
	parameter int SLOTS  = dcm_pkg::SLOT_N
) (
	input  wire logic                  mclk_in,
	input  wire logic                  resetn_in,
	input  wire dcm_pkg::dcm_chan_cfg_s cfg_a_in,
	input  wire dcm_pkg::dcm_chan_cfg_s cfg_b_in,
	input  wire logic                  a_on_phys1_in,
	input  wire logic [ADDR_W-1:0]     zone_top_in,
	input  wire dcm_pkg::dcm_spd_s     spd_a_in [SLOTS],
	input  wire dcm_pkg::dcm_spd_s     spd_b_in [SLOTS],
	input  wire logic [1:0]            rcd_pick_in,
	input  wire logic [1:0]            cwl_pick_in,
	input  wire logic                  req0_valid_in,
	input  wire logic [ADDR_W-1:0]     req0_addr_in,
	input  wire logic                  req1_valid_in,
	input  wire logic [ADDR_W-1:0]     req1_addr_in,
	output logic                       req0_ready_out,
	output logic                       req1_ready_out,
	output dcm_pkg::dcm_route_s        phys0_cmd_out,
	output dcm_pkg::dcm_route_s        phys1_cmd_out,
	output dcm_pkg::dcm_timing_s       timing_out,
	output logic                       dual_mode_out,
	output logic                       full_interleave_out,
	output logic                       cfg_error_out
);

	typedef enum logic [1:0] {
		DCM_ST_IDLE,
		DCM_ST_SINGLE,
		DCM_ST_DUAL
	} dcm_mode_e;

	typedef struct packed {
		dcm_mode_e            mode;
		logic                 error;
		logic                 full_il;
		dcm_pkg::dcm_timing_s timing;
		dcm_pkg::dcm_route_s  p0;
		dcm_pkg::dcm_route_s  p1;
	} dcm_state_s;

	dcm_state_s st_q;
	dcm_state_s st_d;

	// ------------------------------------------------------------
	// Population and common timing
	// ------------------------------------------------------------
	logic       pop_a;
	logic       pop_b;
	logic       rate_seen;
	logic [1:0] min_rate;
	logic [1:0] eff_rate;
	logic [dcm_pkg::LAT_W-1:0] max_cl;
	logic [dcm_pkg::LAT_W-1:0] max_rcd;
	logic [dcm_pkg::LAT_W-1:0] max_rp;
	logic [dcm_pkg::LAT_W-1:0] max_cwl;
	dcm_pkg::dcm_timing_s      tim;
	logic       any_lp;
	logic       any_odp;
	logic       bad_lp;

	always_comb begin
		dcm_pkg::dcm_spd_s s;
		s         = '0;
		pop_a     = 1'b0;
		pop_b     = 1'b0;
		rate_seen = 1'b0;
		min_rate  = dcm_pkg::RATE_2400;
		max_cl    = '0;
		max_rcd   = '0;
		max_rp    = '0;
		max_cwl   = '0;
		// Up to two connectors per channel are scanned
		for (int i = 0; i < SLOTS; i++) begin
			for (int c = 0; c < 2; c++) begin
				s = (c == 0) ? spd_a_in[i] : spd_b_in[i];
				if (s.present) begin
					if (c == 0) begin
						pop_a = 1'b1;
					end else begin
						pop_b = 1'b1;
					end
					// Slowest module sets the rate
					if (!rate_seen || s.rate < min_rate) begin
						min_rate = s.rate;
					end
					rate_seen = 1'b1;
					// Slower latency is used for both channels
					if (s.cl > max_cl) begin
						max_cl = s.cl;
					end
					if (s.rcd > max_rcd) begin
						max_rcd = s.rcd;
					end
					if (s.rp > max_rp) begin
						max_rp = s.rp;
					end
					if (s.cwl > max_cwl) begin
						max_cwl = s.cwl;
					end
				end
			end
		end
	end

	// Technology may differ per channel; any LPDDR3 side steers timing
	assign any_lp  = (cfg_a_in.tech == dcm_pkg::DCM_TECH_LP3) ||
	                 (cfg_b_in.tech == dcm_pkg::DCM_TECH_LP3);
	assign any_odp = (cfg_a_in.tech == dcm_pkg::DCM_TECH_LP3 &&
	                  cfg_a_in.dies == dcm_pkg::LP_ODP_DIES) ||
	                 (cfg_b_in.tech == dcm_pkg::DCM_TECH_LP3 &&
	                  cfg_b_in.dies == dcm_pkg::LP_ODP_DIES);

	// Octa-die LPDDR3 packages cap the rate at 1866
	always_comb begin
		eff_rate = min_rate;
		// Codes above the fastest set fall back to it
		if (min_rate > dcm_pkg::RATE_2400) begin
			eff_rate = dcm_pkg::RATE_2400;
		end
		if (any_odp) begin
			eff_rate = dcm_pkg::RATE_1866;
		end else if (any_lp && eff_rate == dcm_pkg::RATE_2400) begin
			eff_rate = dcm_pkg::RATE_2133;
		end
	end

	// Out-of-range package shapes raise the error flag
	assign bad_lp =
		(cfg_a_in.tech == dcm_pkg::DCM_TECH_LP3 &&
		 (cfg_a_in.banks != dcm_pkg::LP_BANKS ||
		  cfg_a_in.ranks == 2'h0 ||
		  cfg_a_in.ranks > dcm_pkg::LP_MAX_RANKS)) ||
		(cfg_b_in.tech == dcm_pkg::DCM_TECH_LP3 &&
		 (cfg_b_in.banks != dcm_pkg::LP_BANKS ||
		  cfg_b_in.ranks == 2'h0 ||
		  cfg_b_in.ranks > dcm_pkg::LP_MAX_RANKS));

	// Settle on a supported timing set, at a rate never faster than the modules
	always_comb begin
		tim           = '0;
		tim.rate      = eff_rate;
		tim.two_cycle = cfg_a_in.two_cycle | cfg_b_in.two_cycle;
		if (any_lp) begin
			if (eff_rate == dcm_pkg::RATE_1866) begin
				tim.cl     = dcm_pkg::LP_1866_CL;
				tim.rcd    = dcm_pkg::LP_1866_RCD;
				tim.rp     = dcm_pkg::LP_1866_RPPB;
				tim.rp_all = dcm_pkg::LP_1866_RPAB;
				tim.cwl    = dcm_pkg::LP_1866_CWL;
			end else begin
				tim.cl     = dcm_pkg::LP_2133_CL;
				tim.rcd    = dcm_pkg::LP_2133_RCD;
				tim.rp     = dcm_pkg::LP_2133_RPPB;
				tim.rp_all = dcm_pkg::LP_2133_RPAB;
				tim.cwl    = dcm_pkg::LP_2133_CWL;
			end
		end else if (eff_rate == dcm_pkg::RATE_2400) begin
			// 2400 supports only the two-cycle spacing mode
			tim.cl        = dcm_pkg::D4_2400_ALL;
			tim.rcd       = dcm_pkg::D4_2400_ALL;
			tim.rp        = dcm_pkg::D4_2400_ALL;
			tim.rp_all    = dcm_pkg::D4_2400_ALL;
			tim.two_cycle = 1'b1;
			tim.cwl       = (cwl_pick_in == 2'h0) ?
			                dcm_pkg::D4_2400_CWL_A :
			                dcm_pkg::D4_2400_CWL_B;
			// Raised to the longer setting when shorter than a module's own write latency
			if (tim.cwl < max_cwl) begin
				tim.cwl = dcm_pkg::D4_2400_CWL_B;
			end
		end else begin
			tim.cl  = (max_cl > dcm_pkg::D4_2133_CL_A) ?
			          dcm_pkg::D4_2133_CL_B : dcm_pkg::D4_2133_CL_A;
			tim.rp  = (max_rp > dcm_pkg::D4_2133_CL_A) ?
			          dcm_pkg::D4_2133_CL_B : dcm_pkg::D4_2133_CL_A;
			// Pick 14..16, raised if a module needs longer, but never past 16
			tim.rcd = dcm_pkg::D4_2133_RCD_A +
			          dcm_pkg::LAT_W'(rcd_pick_in);
			if (tim.rcd < max_rcd) begin
				tim.rcd = max_rcd;
			end
			if (tim.rcd > dcm_pkg::D4_2133_RCD_C) begin
				tim.rcd = dcm_pkg::D4_2133_RCD_C;
			end
			tim.rp_all = tim.rp;
			tim.cwl    = (cwl_pick_in == 2'h0) ?
			             dcm_pkg::D4_2133_CWL_A :
			             dcm_pkg::D4_2133_CWL_B;
			if (tim.cwl < max_cwl) begin
				tim.cwl = dcm_pkg::D4_2133_CWL_B;
			end
		end
	end

	// ------------------------------------------------------------
	// Address mapping
	// ------------------------------------------------------------
	logic [ADDR_W-1:0] sym_top;
	logic [ADDR_W-1:0] zone_lim;
	logic              dual;

	// Platform must populate both for dual, one for single
	assign dual = pop_a && pop_b;

	// Symmetric zone per channel is the smaller size, or half the boundary
	always_comb begin
		sym_top  = cfg_b_in.size;
		if (cfg_a_in.size < cfg_b_in.size) begin
			sym_top = cfg_a_in.size;
		end
		zone_lim = sym_top;
		if ((zone_top_in >> 1) < sym_top) begin
			zone_lim = zone_top_in >> 1;
		end
	end

	function automatic dcm_pkg::dcm_route_s map_addr(
		input logic [ADDR_W-1:0] a,
		input logic              v
	);
		dcm_pkg::dcm_route_s r;
		logic                lc;
		logic [ADDR_W-1:0]   span;
		r     = '0;
		lc    = 1'b0;
		span  = ADDR_W'({zone_lim, 1'b0});
		r.valid = v;
		if (st_q.mode == DCM_ST_SINGLE) begin
			// Whichever channel is populated gets all traffic
			lc     = !pop_a;
			r.addr = a;
		end else if (a < span) begin
			// Line bit picks channel, remaining bits close the gap
			lc     = a[dcm_pkg::LINE_LSB];
			r.addr = {1'b0, a[ADDR_W-1:dcm_pkg::LINE_LSB+1],
			          a[dcm_pkg::LINE_LSB-1:0]};
		end else begin
			// Remainder lives on the larger channel, after its share
			lc     = cfg_b_in.size > cfg_a_in.size;
			r.addr = ADDR_W'(a - span + zone_lim);
		end
		// Logical A may sit on either physical channel
		r.chan = lc ^ a_on_phys1_in;
		return r;
	endfunction

	dcm_pkg::dcm_route_s rt0;
	dcm_pkg::dcm_route_s rt1;
	logic                want0_p0;
	logic                want0_p1;
	logic                want1_p0;
	logic                want1_p1;
	logic                g0;
	logic                g1;
	logic                pace_two;

	// Procedural, so a mode or size change also re-runs the map
	always_comb begin
		rt0 = map_addr(req0_addr_in, req0_valid_in);
		rt1 = map_addr(req1_addr_in, req1_valid_in);
	end
	assign pace_two = st_q.timing.two_cycle;

	// Requests on opposite channels go out together, no waiting on data
	assign want0_p0 = rt0.valid && !rt0.chan && st_q.mode != DCM_ST_IDLE;
	assign want0_p1 = rt0.valid && rt0.chan && st_q.mode != DCM_ST_IDLE;
	assign want1_p0 = rt1.valid && !rt1.chan && !want0_p0 &&
	                  st_q.mode != DCM_ST_IDLE;
	assign want1_p1 = rt1.valid && rt1.chan && !want0_p1 &&
	                  st_q.mode != DCM_ST_IDLE;

	// One spacing gate per physical channel
	dcm_cmd_pace u_pace0 (
		.mclk_in      (mclk_in),
		.resetn_in    (resetn_in),
		.two_cycle_in (pace_two),
		.req_in       (want0_p0 || want1_p0),
		.grant_out    (g0)
	);

	dcm_cmd_pace u_pace1 (
		.mclk_in      (mclk_in),
		.resetn_in    (resetn_in),
		.two_cycle_in (pace_two),
		.req_in       (want0_p1 || want1_p1),
		.grant_out    (g1)
	);

	// Ready is combinational; the command follows one clock later
	assign req0_ready_out = (want0_p0 && g0) || (want0_p1 && g1);
	assign req1_ready_out = (want1_p0 && g0) || (want1_p1 && g1);

	// ------------------------------------------------------------
	// State update
	// ------------------------------------------------------------
	always_comb begin
		st_d        = st_q;
		st_d.timing = tim;
		st_d.error  = bad_lp || (dual && cfg_a_in.size < cfg_b_in.size);
		if (dual) begin
			st_d.mode = DCM_ST_DUAL;
		end else if (pop_a || pop_b) begin
			st_d.mode = DCM_ST_SINGLE;
		end else begin
			st_d.mode = DCM_ST_IDLE;
		end
		// Equal sizes with boundary at the top: fully interleaved
		st_d.full_il = dual && cfg_a_in.size == cfg_b_in.size &&
		               zone_top_in >= ADDR_W'({cfg_a_in.size, 1'b0});
		st_d.p0 = '0;
		st_d.p1 = '0;
		if (g0) begin
			st_d.p0 = want0_p0 ? rt0 : rt1;
		end
		if (g1) begin
			st_d.p1 = want0_p1 ? rt0 : rt1;
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign phys0_cmd_out       = st_q.p0;
	assign phys1_cmd_out       = st_q.p1;
	assign timing_out          = st_q.timing;
	assign dual_mode_out       = st_q.mode == DCM_ST_DUAL;
	assign full_interleave_out = st_q.full_il;
	assign cfg_error_out       = st_q.error;

endmodule

// ==== hdl/dcm_pkg.sv ====
// Constants and carrier types for the memory channel organization block.
// Assumes one memory clock; configuration bits arrive as plain ports.
package dcm_pkg;

	localparam int ADDR_W    = 36;
	localparam int LINE_LSB  = 6;
	localparam int LAT_W     = 5;
	localparam int SLOT_N    = 2;

	// Rate codes: ascending speed so the minimum is the slowest
	localparam logic [1:0] RATE_1866 = 2'h0;
	localparam logic [1:0] RATE_2133 = 2'h1;
	localparam logic [1:0] RATE_2400 = 2'h2;

	localparam logic [LAT_W-1:0] D4_2133_CL_A  = 5'h0f;
	localparam logic [LAT_W-1:0] D4_2133_CL_B  = 5'h10;
	localparam logic [LAT_W-1:0] D4_2133_RCD_A = 5'h0e;
	localparam logic [LAT_W-1:0] D4_2133_RCD_C = 5'h10;
	localparam logic [LAT_W-1:0] D4_2133_CWL_A = 5'h0b;
	localparam logic [LAT_W-1:0] D4_2133_CWL_B = 5'h0e;
	localparam logic [LAT_W-1:0] D4_2400_ALL   = 5'h11;
	localparam logic [LAT_W-1:0] D4_2400_CWL_A = 5'h0c;
	localparam logic [LAT_W-1:0] D4_2400_CWL_B = 5'h10;
	localparam logic [LAT_W-1:0] LP_1866_CL    = 5'h0e;
	localparam logic [LAT_W-1:0] LP_1866_RCD   = 5'h11;
	localparam logic [LAT_W-1:0] LP_1866_RPPB  = 5'h11;
	localparam logic [LAT_W-1:0] LP_1866_RPAB  = 5'h14;
	localparam logic [LAT_W-1:0] LP_1866_CWL   = 5'h0b;
	localparam logic [LAT_W-1:0] LP_2133_CL    = 5'h10;
	localparam logic [LAT_W-1:0] LP_2133_RCD   = 5'h14;
	localparam logic [LAT_W-1:0] LP_2133_RPPB  = 5'h14;
	localparam logic [LAT_W-1:0] LP_2133_RPAB  = 5'h17;
	localparam logic [LAT_W-1:0] LP_2133_CWL   = 5'h0d;
	localparam logic [3:0] LP_BANKS     = 4'h8;
	localparam logic [3:0] LP_ODP_DIES  = 4'h8;
	localparam logic [1:0] LP_MAX_RANKS = 2'h2;
	localparam logic [15:0] PAGE_BYTES  = 16'h2000;

	typedef enum logic [1:0] {
		DCM_TECH_NONE,
		DCM_TECH_DDR4,
		DCM_TECH_LP3
	} dcm_tech_e;

	// Presence-detect summary of one module slot
	typedef struct packed {
		logic             present;
		logic [1:0]       rate;
		logic [LAT_W-1:0] cl;
		logic [LAT_W-1:0] rcd;
		logic [LAT_W-1:0] rp;
		logic [LAT_W-1:0] cwl;
	} dcm_spd_s;

	typedef struct packed {
		dcm_tech_e        tech;
		logic             two_cycle;
		logic [1:0]       ranks;
		logic [3:0]       dies;
		logic [3:0]       banks;
		logic [ADDR_W-1:0] size;
	} dcm_chan_cfg_s;

	typedef struct packed {
		logic [1:0]       rate;
		logic [LAT_W-1:0] cl;
		logic [LAT_W-1:0] rcd;
		logic [LAT_W-1:0] rp;
		logic [LAT_W-1:0] rp_all;
		logic [LAT_W-1:0] cwl;
		logic             two_cycle;
	} dcm_timing_s;

	typedef struct packed {
		logic              valid;
		logic              chan;
		logic [ADDR_W-1:0] addr;
	} dcm_route_s;

endpackage

// ==== hdl/dcm_cmd_pace.sv ====
// Command spacing gate for one physical channel.
// Assumes a request is held until taken.
`timescale 1ns/100ps
module dcm_cmd_pace (
	input  wire logic mclk_in,
	input  wire logic resetn_in,
	input  wire logic two_cycle_in,
	input  wire logic req_in,
	output logic      grant_out
);

	typedef struct packed {
		logic gap;
	} dcm_pace_s;

	dcm_pace_s st_q;
	dcm_pace_s st_d;

	// 1N grants every clock; 2N blocks the clock after a grant
	assign grant_out = req_in && !(two_cycle_in && st_q.gap);

	always_comb begin
		st_d     = st_q;
		st_d.gap = grant_out && two_cycle_in;
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// ==== verif/dcm_dram_model.sv ====
// Memory-device model of one channel: presence-detect and command count.
// Assumes the bench sets each slot profile; commands arrive as pulses.
`timescale 1ns/100ps
module dcm_dram_model (
	input  wire logic                mclk_in,
	input  wire logic                resetn_in,
	input  wire dcm_pkg::dcm_spd_s   prof_in [2],
	input  wire dcm_pkg::dcm_route_s cmd_in,
	output dcm_pkg::dcm_spd_s        spd_out [2],
	output logic [7:0]               hits_out
);
	// ---
	// Presence detect, two slots
	// ---
	// Empty slot shows inverted fields, so stale data never looks valid
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			spd_out[i] = prof_in[i].present ? prof_in[i] : ~prof_in[i];
			spd_out[i].present = prof_in[i].present;
		end
	end

	// ---
	// Command counter
	// ---
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			hits_out <= 8'h00;
		end else if (cmd_in.valid) begin
			hits_out <= hits_out + 8'h01;
		end
	end
endmodule

// ==== verif/dcm_top_sva.sv ====
// Checker for the channel organizer, bound to its top module.
// Assumes setup changes only while no request is pending.
`timescale 1ns/100ps
module dcm_top_sva #(
	parameter int ADDR_W = dcm_pkg::ADDR_W
) (
	input wire logic                   mclk_in,
	input wire logic                   resetn_in,
	input wire dcm_pkg::dcm_chan_cfg_s cfg_a_in,
	input wire dcm_pkg::dcm_chan_cfg_s cfg_b_in,
	input wire logic                   a_on_phys1_in,
	input wire logic                   req0_valid_in,
	input wire logic [ADDR_W-1:0]      req0_addr_in,
	input wire logic                   req1_valid_in,
	input wire logic                   req0_ready_out,
	input wire logic                   req1_ready_out,
	input wire dcm_pkg::dcm_route_s    phys0_cmd_out,
	input wire dcm_pkg::dcm_route_s    phys1_cmd_out,
	input wire dcm_pkg::dcm_timing_s   timing_out,
	input wire logic                   dual_mode_out,
	input wire logic                   full_interleave_out
);
	logic              take0, pair, solo, ilv, fast, lp2;
	logic [ADDR_W-1:0] got;
	assign take0 = req0_valid_in && req0_ready_out;
	assign pair = take0 && req1_valid_in && req1_ready_out;
	assign solo = take0 && !req1_valid_in;
	assign ilv = solo && dual_mode_out && full_interleave_out;
	assign fast = timing_out.rate == dcm_pkg::RATE_2400;
	assign lp2 = cfg_a_in.tech == dcm_pkg::DCM_TECH_LP3
		&& cfg_b_in.tech == dcm_pkg::DCM_TECH_LP3;
	assign got = phys0_cmd_out.valid ? phys0_cmd_out.addr : phys1_cmd_out.addr;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);

	a_taken_issues: assert property (
		take0 |=> phys0_cmd_out.valid || phys1_cmd_out.valid)
		else $error("taken request not issued");
	a_two_cycle_gap: assert property (
		timing_out.two_cycle |-> !(phys0_cmd_out.valid
		&& $past(phys0_cmd_out.valid)) && !(phys1_cmd_out.valid
		&& $past(phys1_cmd_out.valid)))
		else $error("commands closer than two clocks");
	a_pair_issue: assert property (
		pair |=> phys0_cmd_out.valid && phys1_cmd_out.valid)
		else $error("paired lines not issued together");
	a_line_alternate: assert property (
		ilv |=> phys1_cmd_out.valid == ($past(req0_addr_in[6])
		^ $past(a_on_phys1_in)) && phys0_cmd_out.valid != phys1_cmd_out.valid)
		else $error("line went to wrong channel");
	a_interleave_addr: assert property (
		ilv |=> got == {1'h0, $past(req0_addr_in[ADDR_W-1:7]),
		$past(req0_addr_in[5:0])})
		else $error("interleaved address wrong");
	a_single_addr: assert property (
		solo && !dual_mode_out |=> got == $past(req0_addr_in))
		else $error("single channel address changed");
	a_fast_latency: assert property (
		fast |-> timing_out.two_cycle && timing_out.cl == 5'h11
		&& timing_out.rcd == 5'h11 && timing_out.rp == 5'h11)
		else $error("fast rate timing set wrong");
	a_fast_write_lat: assert property (
		fast |-> timing_out.cwl == 5'h0c || timing_out.cwl == 5'h10)
		else $error("fast rate write latency wrong");
	a_lp_precharge: assert property (
		lp2 && $stable(cfg_a_in) && $stable(cfg_b_in) && $stable(timing_out)
		&& timing_out.cl != 5'h00 |-> timing_out.rp_all == timing_out.rp + 5'h03)
		else $error("all-bank precharge wrong");
	a_lp_die_cap: assert property (
		cfg_a_in.tech == dcm_pkg::DCM_TECH_LP3 && cfg_a_in.dies == 4'h8
		&& $stable(cfg_a_in) |-> timing_out.rate == dcm_pkg::RATE_1866)
		else $error("eight-die rate not capped");
endmodule

bind dcm_top dcm_top_sva #(.ADDR_W(ADDR_W)) u_sva (
	.mclk_in(mclk_in), .resetn_in(resetn_in), .cfg_a_in(cfg_a_in),
	.cfg_b_in(cfg_b_in), .a_on_phys1_in(a_on_phys1_in),
	.req0_valid_in(req0_valid_in), .req0_addr_in(req0_addr_in),
	.req1_valid_in(req1_valid_in), .req0_ready_out(req0_ready_out),
	.req1_ready_out(req1_ready_out), .phys0_cmd_out(phys0_cmd_out),
	.phys1_cmd_out(phys1_cmd_out), .timing_out(timing_out),
	.dual_mode_out(dual_mode_out),
	.full_interleave_out(full_interleave_out));

// ==== verif/dram_channel_organization_tb_top.sv ====
// Bench: channel modes, address routing and common timing.
// Assumes one clock; the models supply presence-detect data.
`timescale 1ns/100ps
module dram_channel_organization_tb_top;
	localparam logic [15:0] SZ = 16'h1000;
	localparam logic [15:0] SZ2 = 16'h2000;
	localparam logic [1:0] K18 = dcm_pkg::RATE_1866;
	localparam logic [1:0] K21 = dcm_pkg::RATE_2133;
	localparam logic [1:0] K24 = dcm_pkg::RATE_2400;
	localparam dcm_pkg::dcm_tech_e D4 = dcm_pkg::DCM_TECH_DDR4;
	localparam dcm_pkg::dcm_tech_e LP = dcm_pkg::DCM_TECH_LP3;
	localparam dcm_pkg::dcm_spd_s NO = '0;
	localparam dcm_pkg::dcm_spd_s D15 = '{1'h1, K21, 5'h0f, 5'h0e, 5'h0f, 5'h0b};
	localparam dcm_pkg::dcm_spd_s D16 = '{1'h1, K24, 5'h10, 5'h0f, 5'h10, 5'h0e};
	localparam dcm_pkg::dcm_spd_s D17 = '{1'h1, K24, 5'h11, 5'h11, 5'h11, 5'h0c};
	localparam dcm_pkg::dcm_spd_s L18 = '{1'h1, K18, 5'h0e, 5'h11, 5'h11, 5'h0b};
	localparam dcm_pkg::dcm_spd_s L21 = '{1'h1, K21, 5'h10, 5'h14, 5'h14, 5'h0d};

	logic                   mclk_in = 1'h0;
	logic                   resetn_in = 1'h0;
	logic                   swap, r0v, r1v, rdy0, rdy1, dual, fint, cerr, rk;
	logic [1:0]             rcd_pick, cwl_pick;
	logic [7:0]             hits0, cnt;
	logic [35:0]            zone, r0a, r1a;
	dcm_pkg::dcm_chan_cfg_s cfg_a, cfg_b;
	dcm_pkg::dcm_spd_s      prof_a [2], prof_b [2], spd_a [2], spd_b [2];
	dcm_pkg::dcm_route_s    p0, p1, g0, g1;
	dcm_pkg::dcm_timing_s   tim;
	int                     failures, num_checks;

	always #10 mclk_in = ~mclk_in;

	dcm_top u_dut (
		.mclk_in(mclk_in), .resetn_in(resetn_in), .cfg_a_in(cfg_a),
		.cfg_b_in(cfg_b), .a_on_phys1_in(swap), .zone_top_in(zone),
		.spd_a_in(spd_a), .spd_b_in(spd_b), .rcd_pick_in(rcd_pick),
		.cwl_pick_in(cwl_pick), .req0_valid_in(r0v), .req0_addr_in(r0a),
		.req1_valid_in(r1v), .req1_addr_in(r1a), .req0_ready_out(rdy0),
		.req1_ready_out(rdy1), .phys0_cmd_out(p0), .phys1_cmd_out(p1),
		.timing_out(tim), .dual_mode_out(dual), .full_interleave_out(fint),
		.cfg_error_out(cerr));
	// Model 0 counts physical channel 0 but reports logical A's slots
	dcm_dram_model u_ch0 (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.prof_in(prof_a), .cmd_in(p0), .spd_out(spd_a), .hits_out(hits0));
	dcm_dram_model u_ch1 (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.prof_in(prof_b), .cmd_in(p1), .spd_out(spd_b), .hits_out());

	// ---
	// Helpers
	// ---
	function automatic dcm_pkg::dcm_chan_cfg_s cc(input dcm_pkg::dcm_tech_e t,
		input logic [3:0] d, input logic [3:0] b, input logic [15:0] s);
		return '{t, 1'h0, (d == 4'h8) ? 2'h2 : 2'h1, d, b, 36'(s)};
	endfunction

	task automatic chk(input string nm, input logic [79:0] e, g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tchk(input logic [1:0] r, input logic [4:0] cl, rcd, rp,
		cwl, input logic tw);
		chk("timing", {r, cl, rcd, rp, cwl, tw},
			{tim.rate, tim.cl, tim.rcd, tim.rp, tim.cwl, tim.two_cycle});
	endtask

	// Setup is changed only while idle; the design loads it on the next edge
	task automatic setup(input dcm_pkg::dcm_chan_cfg_s a, b,
		input dcm_pkg::dcm_spd_s a0, a1, b0, input logic [15:0] z,
		input logic sw);
		@(posedge mclk_in);
		cfg_a <= a;
		cfg_b <= b;
		prof_a <= '{a0, a1};
		prof_b <= '{b0, NO};
		zone <= 36'(z);
		swap <= sw;
		repeat (3) @(posedge mclk_in);
		#1;
	endtask

	task automatic picks(input logic [1:0] r, c);
		@(posedge mclk_in);
		rcd_pick <= r;
		cwl_pick <= c;
		repeat (3) @(posedge mclk_in);
		#1;
	endtask

	task automatic issue(input logic [15:0] a0, a1, input logic v1);
		int n;
		@(posedge mclk_in);
		r0v <= 1'h1;
		r0a <= 36'(a0);
		r1v <= v1;
		r1a <= 36'(a1);
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (rdy0 !== 1'h1 && n < 20);
		rk = rdy1;
		r0v <= 1'h0;
		r1v <= 1'h0;
		#1;
		g0 = p0;
		g1 = p1;
		if (n >= 20) chk("ready", 80'h1, 80'h0);
	endtask

	task automatic route(input logic c, input logic [15:0] a);
		chk("route", {~c, c, 1'h0, 36'(a)},
			{g0.valid, g1.valid, rk, c ? g1.addr : g0.addr});
	endtask

	task automatic pair(input logic [15:0] a, b);
		chk("pair", {2'h3, 1'h1, 36'(a), 36'(b)},
			{g0.valid, g1.valid, rk, g0.addr, g1.addr});
	endtask

	// Request held eight edges to channel 0; counts what the model saw
	task automatic burst(input logic [7:0] e);
		logic [7:0] h;
		@(posedge mclk_in);
		h = hits0;
		r0v <= 1'h1;
		r0a <= '0;
		repeat (8) @(posedge mclk_in);
		r0v <= 1'h0;
		repeat (2) @(posedge mclk_in);
		chk("burst", e, hits0 - h);
	endtask

	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ---
	// Tests
	// ---
	initial begin
		failures = 0;
		num_checks = 0;
		{swap, r0v, r1v, rcd_pick, cwl_pick, zone, r0a, r1a} = '0;
		{cfg_a, cfg_b} = '0;
		prof_a = '{NO, NO};
		prof_b = '{NO, NO};
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1'h1;
		setup(cc(D4, 8, 8, SZ), cc(D4, 8, 8, SZ), D15, NO, D15, SZ2, 1'h0);
		chk("modes", 3'h6, {dual, fint, cerr});
		tchk(K21, 5'h0f, 5'h0e, 5'h0f, 5'h0b, 1'h0);
		issue(16'h0000, 16'h0040, 1'h1);
		pair(16'h0000, 16'h0000);
		issue(16'h0080, 16'h00c0, 1'h1);
		pair(16'h0040, 16'h0040);
		issue(16'h01c0, 16'h0000, 1'h0);
		route(1'h1, 16'h00c0);
		burst(8'h08);
		picks(2'h3, 2'h1);
		tchk(K21, 5'h0f, 5'h10, 5'h0f, 5'h0e, 1'h0);
		// Mixed speeds and latencies, logical A swapped onto channel 1
		setup(cc(D4, 8, 8, SZ), cc(D4, 8, 8, SZ), D15, D16, D15, SZ2, 1'h1);
		tchk(K21, 5'h10, 5'h10, 5'h10, 5'h0e, 1'h0);
		issue(16'h0040, 16'h0000, 1'h0);
		route(1'h0, 16'h0000);
		setup(cc(D4, 8, 8, SZ), cc(D4, 8, 8, SZ), D17, NO, D17, SZ2, 1'h0);
		tchk(K24, 5'h11, 5'h11, 5'h11, 5'h10, 1'h1);
		burst(8'h04);
		picks(2'h3, 2'h0);
		tchk(K24, 5'h11, 5'h11, 5'h11, 5'h0c, 1'h1);
		setup(cc(D4, 8, 8, SZ), cc(D4, 8, 8, SZ), D16, NO, D16, SZ2, 1'h0);
		tchk(K24, 5'h11, 5'h11, 5'h11, 5'h10, 1'h1);
		// Asymmetric: A twice B
		setup(cc(D4, 8, 8, SZ2), cc(D4, 8, 8, SZ), D15, NO, D15, SZ2, 1'h0);
		chk("modes", 3'h4, {dual, fint, cerr});
		issue(16'h2040, 16'h0000, 1'h0);
		route(1'h0, 16'h1040);
		issue(16'h0040, 16'h0000, 1'h0);
		route(1'h1, 16'h0000);
		setup(cc(D4, 8, 8, SZ), cc(D4, 8, 8, SZ2), D15, NO, D15, SZ2, 1'h0);
		chk("cfg_error", 1'h1, cerr);
		setup(cc(dcm_pkg::DCM_TECH_NONE, 0, 0, 0), cc(D4, 8, 8, SZ), NO, NO, D15,
			16'h0000, 1'h0);
		chk("dual", 1'h0, dual);
		issue(16'h01c0, 16'h0000, 1'h0);
		route(1'h1, 16'h01c0);
		setup(cc(LP, 2, 8, SZ), cc(LP, 2, 8, SZ), L18, NO, L18, SZ2, 1'h0);
		tchk(K18, 5'h0e, 5'h11, 5'h11, 5'h0b, 1'h0);
		chk("rp_all", 5'h14, tim.rp_all);
		setup(cc(LP, 2, 8, SZ), cc(LP, 2, 8, SZ), L21, NO, L21, SZ2, 1'h0);
		tchk(K21, 5'h10, 5'h14, 5'h14, 5'h0d, 1'h0);
		chk("rp_all", 5'h17, tim.rp_all);
		setup(cc(LP, 8, 8, SZ), cc(LP, 2, 8, SZ), L21, NO, L21, SZ2, 1'h0);
		chk("rate", K18, tim.rate);
		setup(cc(LP, 2, 4, SZ), cc(LP, 2, 8, SZ), L21, NO, L21, SZ2, 1'h0);
		chk("cfg_error", 1'h1, cerr);
		setup(cc(LP, 2, 8, SZ), cc(D4, 8, 8, SZ), L21, NO, D15, SZ2, 1'h0);
		chk("cfg_error", 1'h0, cerr);
		issue(16'h0000, 16'h0040, 1'h1);
		pair(16'h0000, 16'h0000);
		results();
	end

	// Whole run is about a hundred clocks; this is ample margin
	initial begin
		#50000;
		failures++;
		results();
	end
endmodule
